// ===== hw/converter_fine_gain_trim_regs.sv
/*
  Fine gain trim register bank for converter cores 3, 4 and 5.
  Holds four 8-bit registers, a fuse reload control and a load status.
  Assumes the register master and the input pair select share clk_sys_i,
  and that the fuse store answers on the same clock.
*/
`timescale 1ns/1ps
module converter_fine_gain_trim_regs (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [trim_regs_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [trim_regs_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [trim_regs_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic input_pair_d_sel_i,
  output logic fuse_rd_o,
  output logic [trim_regs_pkg::IDX_W-1:0] fuse_addr_o,
  input wire logic [trim_regs_pkg::TRIM_W-1:0] fuse_data_i,
  output logic [trim_regs_pkg::TRIM_W-1:0] core3_gain_trim_o,
  output logic [trim_regs_pkg::TRIM_W-1:0] core4_gain_trim_o,
  output logic [trim_regs_pkg::TRIM_W-1:0] core5_gain_trim_o,
  output logic fuse_busy_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [trim_regs_pkg::DATA_W-1:0] trim_r [trim_regs_pkg::NUM_TRIMS];
  logic [trim_regs_pkg::DATA_W-1:0] trim_nxt [trim_regs_pkg::NUM_TRIMS];
  logic [trim_regs_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic [trim_regs_pkg::TRIM_W-1:0] core3_r, core3_nxt;
  logic [trim_regs_pkg::TRIM_W-1:0] core4_r, core4_nxt;
  logic [trim_regs_pkg::TRIM_W-1:0] core5_r, core5_nxt;
  logic done_r, done_nxt;
  logic reload_req;
  logic load_busy;
  logic load_done;
  trim_regs_pkg::fuse_load_s fuse_load;

  // Maps a trim entry index to its register address.
  function automatic logic [trim_regs_pkg::ADDR_W-1:0] trim_addr(
    input logic [trim_regs_pkg::IDX_W-1:0] idx
  );
    logic [trim_regs_pkg::ADDR_W-1:0] a;
    a = trim_regs_pkg::CORE3_INPUT_C_GAIN_TRIM_ADDR;
    case (idx)
      trim_regs_pkg::IDX_CORE3_C: a = trim_regs_pkg::CORE3_INPUT_C_GAIN_TRIM_ADDR;
      trim_regs_pkg::IDX_CORE3_D: a = trim_regs_pkg::CORE3_INPUT_D_GAIN_TRIM_ADDR;
      trim_regs_pkg::IDX_CORE4: a = trim_regs_pkg::CORE4_GAIN_TRIM_ADDR;
      trim_regs_pkg::IDX_CORE5: a = trim_regs_pkg::CORE5_GAIN_TRIM_ADDR;
      default: a = trim_regs_pkg::CORE3_INPUT_C_GAIN_TRIM_ADDR;
    endcase
    return a;
  endfunction : trim_addr

  // ----------------------------------------------------------------------
  // Fuse loader
  // ----------------------------------------------------------------------
  // Writing a one to the reload bit asks for a fresh copy of the fuse
  // words; the loader ignores the request while a load is running.
  assign reload_req = reg_wr_i &&
    (reg_addr_i == trim_regs_pkg::FUSE_RELOAD_CTRL_ADDR) &&
    reg_wdata_i[trim_regs_pkg::RELOAD_BIT];

  fuse_trim_loader #(
    .NUM_ENTRIES(trim_regs_pkg::NUM_TRIMS)
  ) u_loader (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .start_i(reload_req),
    .fuse_rd_o(fuse_rd_o),
    .fuse_addr_o(fuse_addr_o),
    .fuse_data_i(fuse_data_i),
    .load_o(fuse_load),
    .busy_o(load_busy),
    .done_o(load_done)
  );

  // ----------------------------------------------------------------------
  // Trim registers
  // ----------------------------------------------------------------------
  // A software write beats a fuse load aimed at the same register in the
  // same cycle, so the value software last wrote is the one kept.
  // Reserved bits are stored as written; software must keep them zero.
  for (genvar g = 0; g < trim_regs_pkg::NUM_TRIMS; g++) begin : g_trim
    always_comb begin
      trim_nxt[g] = trim_r[g];
      if (fuse_load.valid && (fuse_load.idx == trim_regs_pkg::IDX_W'(g))) begin
        trim_nxt[g] = {trim_regs_pkg::RSVD_DEFAULT, fuse_load.trim};
      end
      if (reg_wr_i && (reg_addr_i == trim_addr(trim_regs_pkg::IDX_W'(g)))) begin
        trim_nxt[g] = reg_wdata_i;
      end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
        trim_r[g] <= trim_regs_pkg::TRIM_RESET;
      end else begin
        trim_r[g] <= trim_nxt[g];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Load status
  // ----------------------------------------------------------------------
  // The done flag marks a finished fuse copy and drops when a new one is
  // accepted; a finish in the same cycle wins over that clear.
  always_comb begin
    done_nxt = done_r;
    if (reload_req && !load_busy) begin
      done_nxt = 1'b0;
    end
    if (load_done) begin
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  // Read data stand only in the cycle after the strobe and are zero
  // otherwise, so a stale value can never be taken for a fresh answer.
  always_comb begin
    rdata_nxt = trim_regs_pkg::UNMAPPED_READ;
    if (reg_rd_i) begin
      case (reg_addr_i)
        trim_regs_pkg::CORE3_INPUT_C_GAIN_TRIM_ADDR: begin
          rdata_nxt = trim_r[trim_regs_pkg::IDX_CORE3_C];
        end
        trim_regs_pkg::CORE3_INPUT_D_GAIN_TRIM_ADDR: begin
          rdata_nxt = trim_r[trim_regs_pkg::IDX_CORE3_D];
        end
        trim_regs_pkg::CORE4_GAIN_TRIM_ADDR: begin
          rdata_nxt = trim_r[trim_regs_pkg::IDX_CORE4];
        end
        trim_regs_pkg::CORE5_GAIN_TRIM_ADDR: begin
          rdata_nxt = trim_r[trim_regs_pkg::IDX_CORE5];
        end
        trim_regs_pkg::FUSE_LOAD_STATUS_ADDR: begin
          rdata_nxt[trim_regs_pkg::STATUS_DONE_BIT] = done_r;
          rdata_nxt[trim_regs_pkg::STATUS_BUSY_BIT] = load_busy;
        end
        default: begin
          rdata_nxt = trim_regs_pkg::UNMAPPED_READ; // Reload bit reads zero.
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Trim outputs to the converter cores
  // ----------------------------------------------------------------------
  // Core 3 has two trims; the input pair select picks one per cycle. The
  // extra flop costs a cycle of lag after a select change but keeps the
  // outputs glitch free toward the analog correction.
  always_comb begin
    if (input_pair_d_sel_i) begin
      core3_nxt = trim_r[trim_regs_pkg::IDX_CORE3_D][trim_regs_pkg::TRIM_W-1:0];
    end else begin
      core3_nxt = trim_r[trim_regs_pkg::IDX_CORE3_C][trim_regs_pkg::TRIM_W-1:0];
    end
    core4_nxt = trim_r[trim_regs_pkg::IDX_CORE4][trim_regs_pkg::TRIM_W-1:0];
    core5_nxt = trim_r[trim_regs_pkg::IDX_CORE5][trim_regs_pkg::TRIM_W-1:0];
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      core3_r <= '0;
      core4_r <= '0;
      core5_r <= '0;
    end else begin
      core3_r <= core3_nxt;
      core4_r <= core4_nxt;
      core5_r <= core5_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign core3_gain_trim_o = core3_r;
  assign core4_gain_trim_o = core4_r;
  assign core5_gain_trim_o = core5_r;
  assign fuse_busy_o = load_busy;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_wr_core3_c;
    reg_wr_i && (reg_addr_i == trim_regs_pkg::CORE3_INPUT_C_GAIN_TRIM_ADDR);
  endsequence

  sequence s_rd_core3_c;
    reg_rd_i && (reg_addr_i == trim_regs_pkg::CORE3_INPUT_C_GAIN_TRIM_ADDR);
  endsequence

  sequence s_wr_core4;
    reg_wr_i && (reg_addr_i == trim_regs_pkg::CORE4_GAIN_TRIM_ADDR);
  endsequence

  sequence s_wr_core5;
    reg_wr_i && (reg_addr_i == trim_regs_pkg::CORE5_GAIN_TRIM_ADDR);
  endsequence

  chk_core3_c_apply: assert property (
    !input_pair_d_sel_i |=>
      core3_gain_trim_o == $past(trim_r[trim_regs_pkg::IDX_CORE3_C][4:0]))
    else $error("core 3 trim does not follow input C register");

  chk_core3_d_apply: assert property (
    input_pair_d_sel_i |=>
      core3_gain_trim_o == $past(trim_r[trim_regs_pkg::IDX_CORE3_D][4:0]))
    else $error("core 3 trim does not follow input D register");

  chk_core4_write_apply: assert property (
    s_wr_core4 |-> ##2 (core4_gain_trim_o == $past(reg_wdata_i[4:0], 2)))
    else $error("core 4 trim did not take the written value");

  // Neither a write nor a fuse load touches the core 5 register this cycle.
  sequence s_core5_quiet;
    !(reg_wr_i && (reg_addr_i == trim_regs_pkg::CORE5_GAIN_TRIM_ADDR)) &&
      !(fuse_load.valid && (fuse_load.idx == trim_regs_pkg::IDX_CORE5));
  endsequence

  // The written trim reaches core 5 two edges later and stays one more cycle if the next cycle leaves it untouched.
  chk_core5_write_apply: assert property (
    s_wr_core5 ##1 s_core5_quiet |->
      ##1 (core5_gain_trim_o == $past(reg_wdata_i[4:0], 2))
      ##1 (core5_gain_trim_o == $past(reg_wdata_i[4:0], 3)))
    else $error("core 5 trim did not take the written value");

  chk_fuse_fill_reg: assert property (
    (fuse_load.valid && !reg_wr_i) |=>
      trim_r[$past(fuse_load.idx)] == {3'h0, $past(fuse_load.trim)})
    else $error("fuse word not copied into its trim register");

  chk_write_read_back: assert property (
    s_wr_core3_c ##1 s_rd_core3_c |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("read back differs from the last write");

  chk_read_idle_zero: assert property (
    !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data present without a read strobe");

endmodule : converter_fine_gain_trim_regs

// ===== common/trim_regs_pkg.sv
/*
  Shared constants and types for the converter fine gain trim register bank.
  Assumes an 8-bit register port with 12-bit addresses and a small on-chip
  fuse store that returns one 5-bit trim word per index.
*/
package trim_regs_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned TRIM_W = 5;
  localparam int unsigned RSVD_W = 3;
  localparam int unsigned IDX_W = 2;
  localparam int unsigned NUM_TRIMS = 4;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CORE3_INPUT_C_GAIN_TRIM_ADDR = 12'h364;
  localparam logic [ADDR_W-1:0] CORE3_INPUT_D_GAIN_TRIM_ADDR = 12'h365;
  localparam logic [ADDR_W-1:0] CORE4_GAIN_TRIM_ADDR = 12'h366;
  localparam logic [ADDR_W-1:0] CORE5_GAIN_TRIM_ADDR = 12'h367;
  localparam logic [ADDR_W-1:0] FUSE_RELOAD_CTRL_ADDR = 12'h368;
  localparam logic [ADDR_W-1:0] FUSE_LOAD_STATUS_ADDR = 12'h369;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned TRIM_LSB = 0;
  localparam int unsigned RSVD_LSB = 5;
  localparam int unsigned RELOAD_BIT = 0;
  localparam int unsigned STATUS_BUSY_BIT = 1;
  localparam int unsigned STATUS_DONE_BIT = 0;
  localparam logic [DATA_W-1:0] TRIM_RESET = 8'h00;
  localparam logic [RSVD_W-1:0] RSVD_DEFAULT = 3'h0;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------------
  // Trim entry indices, also the fuse word indices
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CORE3_C = 2'h0;
  localparam logic [IDX_W-1:0] IDX_CORE3_D = 2'h1;
  localparam logic [IDX_W-1:0] IDX_CORE4 = 2'h2;
  localparam logic [IDX_W-1:0] IDX_CORE5 = 2'h3;

  // One trim word fetched from fuse storage, aimed at one register.
  typedef struct packed {
    logic valid;
    logic [IDX_W-1:0] idx;
    logic [TRIM_W-1:0] trim;
  } fuse_load_s;

endpackage : trim_regs_pkg

// ===== hw/fuse_trim_loader.sv
/*
  Sequencer that copies the fuse trim words into the trim register bank.
  Assumes the fuse store answers a one-cycle read strobe with data in the
  following cycle and that it sits on the same clock.
*/
`timescale 1ns/1ps
module fuse_trim_loader #(
  parameter int unsigned NUM_ENTRIES = trim_regs_pkg::NUM_TRIMS
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic start_i,
  output logic fuse_rd_o,
  output logic [trim_regs_pkg::IDX_W-1:0] fuse_addr_o,
  input wire logic [trim_regs_pkg::TRIM_W-1:0] fuse_data_i,
  output trim_regs_pkg::fuse_load_s load_o,
  output logic busy_o,
  output logic done_o
);

  localparam logic [trim_regs_pkg::IDX_W-1:0] LAST_IDX =
    trim_regs_pkg::IDX_W'(NUM_ENTRIES - 1);

  typedef enum logic [1:0] {LD_IDLE, LD_READ, LD_TAKE} load_state_e;

  load_state_e state_r, state_nxt;
  logic [trim_regs_pkg::IDX_W-1:0] idx_r, idx_nxt;
  logic rd_r, rd_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic boot_r, boot_nxt;
  trim_regs_pkg::fuse_load_s load_r, load_nxt;

  // ----------------------------------------------------------------------
  // Walk every fuse word once per load; the first load runs by itself.
  // ----------------------------------------------------------------------
  // A start seen while busy is dropped, so a load is never cut in half.
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    rd_nxt = 1'b0;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    boot_nxt = boot_r;
    load_nxt = '0;
    case (state_r)
      LD_IDLE: begin
        if (start_i || boot_r) begin
          boot_nxt = 1'b0;
          idx_nxt = '0;
          rd_nxt = 1'b1;
          busy_nxt = 1'b1;
          state_nxt = LD_READ;
        end
      end
      LD_READ: begin
        state_nxt = LD_TAKE; // Fuse data answers in the next cycle.
      end
      LD_TAKE: begin
        load_nxt.valid = 1'b1;
        load_nxt.idx = idx_r;
        load_nxt.trim = fuse_data_i;
        if (idx_r == LAST_IDX) begin
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          state_nxt = LD_IDLE;
        end else begin
          idx_nxt = idx_r + 1'b1;
          rd_nxt = 1'b1;
          state_nxt = LD_READ;
        end
      end
      default: begin
        state_nxt = LD_IDLE;
      end
    endcase
  end

  // Registers of the sequencer.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= LD_IDLE;
      idx_r <= '0;
      rd_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      boot_r <= 1'b1;
      load_r <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      rd_r <= rd_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      boot_r <= boot_nxt;
      load_r <= load_nxt;
    end
  end

  assign fuse_rd_o = rd_r;
  assign fuse_addr_o = idx_r;
  assign load_o = load_r;
  assign busy_o = busy_r;
  assign done_o = done_r;

  // Every fuse read turns into a load of the same index two cycles later.
  chk_fuse_read_load: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    fuse_rd_o |-> ##2 (load_o.valid && load_o.idx == $past(fuse_addr_o, 2)))
    else $error("fuse read did not produce a trim load");

endmodule : fuse_trim_loader

// ===== verif/converter_fine_gain_trim_regs_tb.sv
/*
  Self-checking testbench for the converter fine gain trim register bank.
  Assumes the design carries its own assertions, a single 40 MHz clock and
  a fuse store that the bench imitates by answering each fuse read strobe.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module converter_fine_gain_trim_regs_tb;
  // ----------------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [trim_regs_pkg::ADDR_W-1:0] reg_addr_i = '0;
  logic [trim_regs_pkg::DATA_W-1:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [trim_regs_pkg::DATA_W-1:0] reg_rdata_o;
  logic input_pair_d_sel_i = 1'b0;
  logic fuse_rd_o;
  logic [trim_regs_pkg::IDX_W-1:0] fuse_addr_o;
  logic [trim_regs_pkg::TRIM_W-1:0] fuse_data_i = '0;
  logic [trim_regs_pkg::TRIM_W-1:0] core3_gain_trim_o;
  logic [trim_regs_pkg::TRIM_W-1:0] core4_gain_trim_o;
  logic [trim_regs_pkg::TRIM_W-1:0] core5_gain_trim_o;
  logic fuse_busy_o;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h26b5;
  logic [trim_regs_pkg::TRIM_W-1:0] fuse_mem [4];
  logic [trim_regs_pkg::DATA_W-1:0] exp_reg [4];
  localparam logic [trim_regs_pkg::ADDR_W-1:0] TRIM_ADDR [4] = '{
    trim_regs_pkg::CORE3_INPUT_C_GAIN_TRIM_ADDR, trim_regs_pkg::CORE3_INPUT_D_GAIN_TRIM_ADDR,
    trim_regs_pkg::CORE4_GAIN_TRIM_ADDR, trim_regs_pkg::CORE5_GAIN_TRIM_ADDR};

  converter_fine_gain_trim_regs u_converter_fine_gain_trim_regs (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .input_pair_d_sel_i(input_pair_d_sel_i),
    .fuse_rd_o(fuse_rd_o),
    .fuse_addr_o(fuse_addr_o),
    .fuse_data_i(fuse_data_i),
    .core3_gain_trim_o(core3_gain_trim_o),
    .core4_gain_trim_o(core4_gain_trim_o),
    .core5_gain_trim_o(core5_gain_trim_o),
    .fuse_busy_o(fuse_busy_o)
  );

  // ----------------------------------------------------------------------
  // Clock, fuse store and hang guard
  // ----------------------------------------------------------------------
  // A 25 ns period gives the 40 MHz system clock.
  always #12.5 clk_sys_i = ~clk_sys_i;

  // The fuse word is valid only in the cycle after the strobe; otherwise the
  // line toggles so that a late sample can never match by luck.
  always @(posedge clk_sys_i) begin
    if (fuse_rd_o === 1'b1) begin
      fuse_data_i <= fuse_mem[fuse_addr_o];
    end else begin
      fuse_data_i <= ~fuse_data_i;
    end
  end

  // The whole sequence needs a few hundred cycles; the ceiling is generous.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Galois shift register, so the random run repeats exactly.
  function automatic logic [31:0] rnd();
    seed = seed[0] ? ((seed >> 1) ^ 32'h80200003) : (seed >> 1);
    return seed;
  endfunction : rnd

  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe edge.
  task automatic reg_read(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : reg_read

  // A write with the read of the same place in the very next cycle.
  task automatic reg_wr_rd(input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    q = reg_rdata_o;
  endtask : reg_wr_rd

  task automatic expect_fuse();
    for (int i = 0; i < 4; i++) begin
      exp_reg[i] = {3'h0, fuse_mem[i]};
    end
  endtask : expect_fuse

  task automatic new_fuse();
    for (int i = 0; i < 4; i++) begin
      fuse_mem[i] = rnd() & 32'h1f;
    end
  endtask : new_fuse

  // Busy rises one edge after the start, then the copy takes bounded time.
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge clk_sys_i);
    while (fuse_busy_o !== 1'b0 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n == 100) begin
      num_errors++;
    end
    repeat (2) @(posedge clk_sys_i);
  endtask : wait_idle

  task automatic check_regs();
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      reg_read(TRIM_ADDR[i], d);
      `CHK(d, exp_reg[i])
    end
  endtask : check_regs

  // Trim outputs settle one edge after the register or the select changes.
  task automatic check_outs();
    @(posedge clk_sys_i);
    #1;
    `CHK(core3_gain_trim_o, exp_reg[input_pair_d_sel_i ? 1 : 0][4:0])
    `CHK(core4_gain_trim_o, exp_reg[2][4:0])
    `CHK(core5_gain_trim_o, exp_reg[3][4:0])
  endtask : check_outs

  task automatic set_sel(input logic v);
    @(posedge clk_sys_i);
    input_pair_d_sel_i <= v;
  endtask : set_sel

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0] d;
    int k;
    new_fuse();
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    // Boot copy must replace the plain zero reset value with fuse words.
    wait_idle();
    expect_fuse();
    check_regs();
    check_outs();
    set_sel(1'b1);
    check_outs();
    set_sel(1'b0);
    check_outs();
    // Boundary trims first, then random traffic, each write read back.
    for (int j = 0; j < 44; j++) begin
      k = (j < 8) ? (j % 4) : (rnd() % 4);
      d = (j < 4) ? 8'h1f : ((j < 8) ? 8'h00 : (rnd() & 32'h1f));
      reg_write(TRIM_ADDR[k], d);
      exp_reg[k] = d;
      set_sel(rnd() & 1);
      check_outs();
      reg_read(TRIM_ADDR[k], d);
      `CHK(d, exp_reg[k])
      #25;
      `CHK(reg_rdata_o, trim_regs_pkg::UNMAPPED_READ)
    end
    // A read straight after a write must already see the new value.
    reg_wr_rd(TRIM_ADDR[0], 8'h15, d);
    exp_reg[0] = 8'h15;
    `CHK(d, exp_reg[0])
    // Unmapped places neither store nor disturb; the control register reads zero.
    reg_write(12'h36a, 8'h15);
    reg_write(12'h363, 8'h15);
    reg_read(12'h36a, d);
    `CHK(d, trim_regs_pkg::UNMAPPED_READ)
    reg_read(12'h363, d);
    `CHK(d, trim_regs_pkg::UNMAPPED_READ)
    reg_read(trim_regs_pkg::FUSE_RELOAD_CTRL_ADDR, d);
    `CHK(d, 8'h00)
    check_regs();
    // Reload on demand brings in fresh fuse words over written values.
    new_fuse();
    reg_write(trim_regs_pkg::FUSE_RELOAD_CTRL_ADDR, 8'h01);
    // Mid-copy the status shows busy and the old done flag cleared.
    reg_read(trim_regs_pkg::FUSE_LOAD_STATUS_ADDR, d);
    `CHK(d, 8'h02)
    wait_idle();
    expect_fuse();
    check_regs();
    check_outs();
    reg_read(trim_regs_pkg::FUSE_LOAD_STATUS_ADDR, d);
    `CHK(d, 8'h01)
    // A second reset in mid-run repeats the boot copy.
    reg_write(TRIM_ADDR[2], 8'h0a);
    new_fuse();
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    wait_idle();
    expect_fuse();
    check_regs();
    set_sel(1'b1);
    check_outs();
    finish_test();
  end
endmodule : converter_fine_gain_trim_regs_tb
